// [bench/serdes_link_partner.sv]
// Purpose: Far-end link model that loops the serial line back into the receiver.
// Assumes: Runs on the core clock; the block samples the line itself.
// Notes: A released or cut line holds the inverse of the last driven level, so a stale level never looks valid.
module serdes_link_partner (
  // Clock
  input wire logic core_clk_i,
  // Near-end serial driver
  input wire logic serial_p_i,
  input wire logic serial_oe_i,
  // Fault control from the bench
  input wire logic cut_i,
  // Line into the receiver
  output logic serial_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  logic last_bit = 1'b0; // Last level seen while the line was driven

  // Frames come back bit for bit, start high and stop low kept in place
  always @(posedge core_clk_i) begin
    if (serial_oe_i && !cut_i) begin
      last_bit <= serial_p_i;
      serial_o <= serial_p_i;
    end else begin
      // Floating line: show the inverse so a stale level never looks valid
      serial_o <= ~last_bit;
    end
  end
endmodule : serdes_link_partner

// [bench/serdes_lock_power_test_ctrl_bench.sv]
// Purpose: Self-checking bench for serdes lock, sleep, enable and test control.
// Assumes: Partner loops the line back; lock and BIST limits are shortened.
// Notes: Random words come from a 16-bit shift register seeded with 67.
module serdes_lock_power_test_ctrl_bench
  import serdes_ctrl_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LK = 300; // Short lock deadline
  localparam int BL = 50; // Short BIST length, frames
  localparam int RF = 4; // Repeats that flag a repetitive pattern
  localparam int FR = FRAME_BITS * BIT_DIV_DEFAULT; // Core cycles per frame
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  reg_req_t req = '0;
  logic transmit_clock = 1'b0;
  logic tq = 1'b0;
  logic [9:0] din = 10'h000;
  logic tx_slp_n = 1'b1;
  logic driver_output_enable = 1'b1;
  logic rx_slp_n = 1'b1;
  logic ren = 1'b1;
  logic cut = 1'b0;
  logic rnd = 1'b1; // Random words on the serializer input
  logic esel = 1'b1; // Edge select, rising edge while high
  logic syn = 1'b0; // Sync request from the bench
  logic [9:0] hold_w = 10'h000; // Word held while random words are off
  logic [15:0] lf = 16'h0043;
  logic [31:0] rdata;
  logic [9:0] dout;
  logic sp, sn, soe, repetitive_multi_transition, rclk, roe, lock_n, lock_oe, sin;
  int num_errors = 0;
  int num_checks = 0;

  // Clocks: core 4 ns, link word clock 125 ns with unrelated phase
  always #2 core_clk_i = ~core_clk_i;
  always #62.5 transmit_clock = ~transmit_clock;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // A low bit just below a high one, bits 0 to 8 only
  function automatic logic is_rmt(input logic [9:0] w);
    return |(~w[8:0] & w[9:1]);
  endfunction : is_rmt

  // New word after each falling link edge, steady at the rising latch
  always @(posedge core_clk_i) begin
    tq <= transmit_clock;
    if (!rnd) begin
      din <= hold_w;
    end else if (tq && !transmit_clock) begin
      lf <= lfsr(lf);
      din <= lf[9:0];
    end
  end

  serdes_lock_power_test_ctrl #(.LOCK_MAX(LK), .BIST_LEN(BL), .RMT_FRAMES(RF)) uut (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .transmit_clock_i(transmit_clock), .transmit_edge_select_i(esel), .parallel_data_in_i(din),
    .sync_request_a_i(syn), .sync_request_b_i(1'b0), .tx_sleep_request_n_i(tx_slp_n),
    .driver_output_enable_i(driver_output_enable), .serial_p_o(sp), .serial_n_o(sn), .serial_oe_o(soe),
    .repetitive_multi_transition_o(repetitive_multi_transition), .serial_in_i(sin), .rx_sleep_request_n_i(rx_slp_n),
    .receiver_output_enable_i(ren), .parallel_data_out_o(dout), .recovered_clock_o(rclk),
    .rx_out_oe_o(roe), .lock_n_o(lock_n), .lock_n_oe_o(lock_oe));

  serdes_link_partner far_end (.core_clk_i(core_clk_i), .serial_p_i(sp),
    .serial_oe_i(soe), .cut_i(cut), .serial_o(sin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Let n edges pass, then settle past the last one
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    req <= '0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    req <= '0;
    #1 d = rdata;
  endtask : reg_rd

  // Bounded wait for the lock indicator to go low
  task automatic wait_lock(input int lim);
    int n;
    n = 0;
    while (lock_n !== 1'b0 && n < lim) begin
      @(posedge core_clk_i);
      n++;
    end
    #1 chk(lock_n, 1'b0, "lock");
  endtask : wait_lock

  // Driver must stay off until the link clock count completes
  task automatic tx_init();
    repeat (500) @(posedge transmit_clock);
    #1 chk(soe, 1'b0, "driver before init");
    repeat (20) @(posedge transmit_clock);
    #1 chk(soe, 1'b1, "driver after init");
  endtask : tx_init

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard, well beyond the two initialisations and the BIST run
  initial begin
    #300us;
    num_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    logic [31:0] v;
    logic [9:0] w;
    logic [15:0] s;
    int hi;
    cyc(11);
    chk({soe, roe, lock_n, lock_oe}, 4'b0010, "reset outputs");
    @(posedge core_clk_i) rst_b_i <= 1'b1;
    reg_rd(REG_CTRL, v);
    chk(v, 32'h0, "ctrl reset");
    reg_rd(4'hc, v);
    chk(v, 32'h0, "unmapped read");
    tx_init();
    wait_lock(2 * LK);
    // Held words: flag, then data, with the bit 9 corner and a low-high pair
    // Held words are latched on the falling link edge
    @(posedge core_clk_i) rnd <= 1'b0;
    esel <= 1'b0;
    s = lf;
    for (int i = 0; i < 6; i++) begin
      s = lfsr(s);
      w = (i == 0) ? 10'h200 : (i == 1) ? 10'h1ff : s[9:0];
      @(posedge core_clk_i) hold_w <= w;
      cyc(FR * (RF + 3));
      chk(repetitive_multi_transition, is_rmt(w), "pattern flag");
      if (!is_rmt(w)) begin
        wait_lock(4 * LK);
        cyc(2 * FR);
        chk(dout, w, "received word");
      end
    end
    // Two clock candidates every frame must hold lock off until data move
    @(posedge core_clk_i) hold_w <= 10'h002;
    cyc(FR * 4 * 8);
    chk(lock_n, 1'b1, "false lock held off");
    reg_rd(REG_STATUS, v);
    chk(v[4], 1'b1, "suspect flag");
    chk(v[7], 1'b1, "lock deadline passed");
    @(posedge core_clk_i) rnd <= 1'b1;
    esel <= 1'b1;
    wait_lock(4 * LK);
    // Receiver sleep needs both pins low; lock stays driven with outputs off
    @(posedge core_clk_i) rx_slp_n <= 1'b0;
    cyc(4);
    chk({roe, lock_oe}, 2'b11, "awake with enable high");
    @(posedge core_clk_i) ren <= 1'b0;
    cyc(4);
    chk({roe, lock_oe}, 2'b00, "rx asleep");
    @(posedge core_clk_i) rx_slp_n <= 1'b1;
    cyc(4);
    chk({roe, lock_oe, lock_n}, 3'b011, "rx woken, outputs off");
    wait_lock(4 * LK);
    @(posedge core_clk_i) ren <= 1'b1;
    cyc(4);
    chk(roe, 1'b1, "rx outputs back");
    // Recovered clock is high for six bit times of every frame
    hi = 0;
    repeat (FR) begin
      cyc(1);
      hi += int'(rclk);
    end
    chk(hi, 6 * BIT_DIV_DEFAULT, "recovered clock high time");
    // Dead line: lock drops and outputs float
    @(posedge core_clk_i) cut <= 1'b1;
    cyc(3 * FR);
    chk({lock_n, roe}, 2'b10, "lock lost");
    @(posedge core_clk_i) cut <= 1'b0;
    wait_lock(4 * LK);
    @(posedge core_clk_i) driver_output_enable <= 1'b0;
    cyc(4);
    chk(soe, 1'b0, "driver off");
    @(posedge core_clk_i) driver_output_enable <= 1'b1;
    cyc(4);
    chk(soe, 1'b1, "driver back");
    // Static connectivity at both levels through the loopback
    for (int k = 0; k < 2; k++) begin
      reg_wr(REG_CTRL, {29'h0, k[0], 2'b10});
      cyc(8);
      chk({soe, sp, sn}, {1'b1, k[0], ~k[0]}, "extest drive");
      reg_rd(REG_STATUS, v);
      chk(v[6], k[0], "extest sense");
    end
    reg_wr(REG_CTRL, 32'h0);
    wait_lock(4 * LK);
    reg_wr(REG_CTRL, 32'h1);
    v = 32'h0;
    for (int n = 0; n < BL * FR && !v[1]; n++) reg_rd(REG_STATUS, v);
    chk(v[2:0], 3'b011, "bist done and passed");
    reg_rd(REG_ERRORS, v);
    chk(v, 32'h0, "bist errors");
    // Sync frame: start high, five data ones, five zeros, stop low
    @(posedge core_clk_i) syn <= 1'b1;
    cyc(FR * 8);
    chk({lock_n, dout}, {1'b0, 10'h01f}, "sync frame received");
    @(posedge core_clk_i) syn <= 1'b0;
    // Serializer sleep ignores the enable; wake needs a full init again
    @(posedge core_clk_i) tx_slp_n <= 1'b0;
    cyc(4);
    chk(soe, 1'b0, "tx asleep");
    @(posedge core_clk_i) tx_slp_n <= 1'b1;
    tx_init();
    wait_lock(4 * LK);
    tally_and_finish();
  end
endmodule : serdes_lock_power_test_ctrl_bench

// [hdl/serdes_ctrl_pkg.sv]
// Purpose: Constants and carriers for the serdes lock, power and test control block.
// Assumes: One 250 MHz core clock; all link and pin inputs sampled through two flops.
// Notes: Serializer and deserializer control share one module and one bit divider.
package serdes_ctrl_pkg;

  // Link framing
  localparam int FRAME_BITS = 12;
  localparam int DATA_BITS = 10;
  localparam logic [11:0] SYNC_FRAME = 12'hfc0;
  localparam int BIT_DIV_DEFAULT = 4;

  // Serializer timing, in transmit clock cycles
  localparam logic [9:0] INIT_TRANSMIT_CLOCK_CYCLES = 10'h1fe;
  localparam logic [2:0] SYNC_HOLD_TRANSMIT_CLOCK = 3'h5;

  // Core clock and derived timing
  localparam int CORE_MHZ = 250;
  localparam int LOCK_MAX_US = 18;
  localparam int LOCK_MAX_CYCLES = LOCK_MAX_US * CORE_MHZ;
  localparam int BIST_TIME_US = 28000;
  localparam int BIST_SYS_MHZ = 80;
  localparam int BIST_FRAMES = BIST_TIME_US * BIST_SYS_MHZ;
  localparam longint BER_DENOM = 64'd10000000;

  // Register offsets and control fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_ERRORS = 4'h8;
  localparam int CTRL_RUNBIST = 0;
  localparam int CTRL_EXTEST = 1;
  localparam int CTRL_EXT_LEVEL = 2;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [9:0] BIST_SEED = 10'h001;

  // Receiver lock states
  typedef enum logic [1:0] {
    RX_SEARCH = 2'b00,
    RX_LOCKED = 2'b01,
    RX_SUSPECT = 2'b10
  } rx_state_t;

  // Status word, low byte of the status register
  typedef struct packed {
    logic lock_slow;
    logic extest_sense;
    logic repetitive_multi_transition;
    logic suspect;
    logic locked;
    logic bist_busy;
    logic bist_complete;
    logic bist_pass;
  } status_t;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : serdes_ctrl_pkg

// [hdl/serdes_lock_power_test_ctrl.sv]
// Purpose: Serializer and deserializer control: framing, random lock, false lock,
//   sleep, output enables, EXTEST and at-speed BIST.
// Assumes: Pins are asynchronous and pass two flops; bit rate is core clock / BIT_DIV.
// Notes: Frames are sent back to back; transmit words not yet sent are overwritten.
module serdes_lock_power_test_ctrl
  import serdes_ctrl_pkg::*;
#(
  parameter int BIT_DIV = BIT_DIV_DEFAULT,
  parameter int WIN_FRAMES = 4,
  parameter int FALSE_LOCK_WINDOWS = 3,
  parameter int RMT_FRAMES = 4,
  parameter int LOCK_MAX = LOCK_MAX_CYCLES,
  parameter int BIST_LEN = BIST_FRAMES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire reg_req_t reg_req_i,
  output logic [31:0] reg_rdata_o,
  // Serializer pins
  input wire logic transmit_clock_i,
  input wire logic transmit_edge_select_i,
  input wire logic [9:0] parallel_data_in_i,
  input wire logic sync_request_a_i,
  input wire logic sync_request_b_i,
  input wire logic tx_sleep_request_n_i,
  input wire logic driver_output_enable_i,
  output logic serial_p_o,
  output logic serial_n_o,
  output logic serial_oe_o,
  output logic repetitive_multi_transition_o,
  // Deserializer pins
  input wire logic serial_in_i,
  input wire logic rx_sleep_request_n_i,
  input wire logic receiver_output_enable_i,
  output logic [9:0] parallel_data_out_o,
  output logic recovered_clock_o,
  output logic rx_out_oe_o,
  output logic lock_n_o,
  output logic lock_n_oe_o
);

  // Reverse a ten bit word, so bit 0 goes first on the wire
  function automatic logic [9:0] rev10(input logic [9:0] v);
    logic [9:0] r;
    r = 10'h000;
    for (int i = 0; i < 10; i++) r[i] = v[9-i];
    return r;
  endfunction : rev10

  // One step of the BIST pattern generator
  function automatic logic [9:0] lfsr10(input logic [9:0] v);
    return {v[8:0], v[9] ^ v[6]};
  endfunction : lfsr10

  // Number of candidate clock positions
  function automatic logic [3:0] count_ones(input logic [11:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 12; i++) n = n + {3'h0, v[i]};
    return n;
  endfunction : count_ones

  // Position of the lowest set candidate
  function automatic logic [3:0] first_one(input logic [11:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 11; i >= 0; i--) if (v[i]) idx = 4'(i);
    return idx;
  endfunction : first_one

  // Pin synchronisers
  logic [18:0] pin_meta; // First stage, read only by pin_sync
  logic [18:0] pin_sync; // Safe copy of all pins
  logic transmit_clock_s, edge_sel_s, sync_a_s, sync_b_s, tx_sleep_n_s, den_s;
  logic sin_s, rx_sleep_n_s, ren_s;
  logic [9:0] din_s;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {transmit_clock_i, transmit_edge_select_i, parallel_data_in_i,
                   sync_request_a_i, sync_request_b_i, tx_sleep_request_n_i,
                   driver_output_enable_i, serial_in_i, rx_sleep_request_n_i,
                   receiver_output_enable_i};
      pin_sync <= pin_meta;
    end
  end

  assign {transmit_clock_s, edge_sel_s, din_s, sync_a_s, sync_b_s, tx_sleep_n_s, den_s,
          sin_s, rx_sleep_n_s, ren_s} = pin_sync;

  // Bit rate divider shared by both directions
  logic [7:0] div_cnt;
  logic bit_en; // One pulse per serial bit

  assign bit_en = (div_cnt == 8'(BIT_DIV - 1));

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || bit_en) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // Transmit clock edge finder
  logic transmit_clock_d, transmit_clock_rise, transmit_clock_pick, tx_sleep, tx_ready, sync_mode;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      transmit_clock_d <= 1'b0;
    end else begin
      transmit_clock_d <= transmit_clock_s;
    end
  end

  assign transmit_clock_rise = transmit_clock_s & ~transmit_clock_d;
  // Edge select high takes rising edges, low takes falling ones
  assign transmit_clock_pick = edge_sel_s ? transmit_clock_rise : (transmit_clock_d & ~transmit_clock_s);
  assign tx_sleep = ~tx_sleep_n_s;

  // Initialization count after reset or sleep exit
  logic [9:0] init_cnt;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || tx_sleep) begin
      init_cnt <= 10'h000;
    end else if (transmit_clock_rise && !tx_ready) begin
      init_cnt <= init_cnt + 10'h001;
    end
  end

  assign tx_ready = (init_cnt == INIT_TRANSMIT_CLOCK_CYCLES);

  // Sync request must be held several transmit clocks before it takes over
  logic [2:0] sync_cnt;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || !(sync_a_s || sync_b_s)) begin
      sync_cnt <= 3'h0;
    end else if (transmit_clock_rise && !sync_mode) begin
      sync_cnt <= sync_cnt + 3'h1;
    end
  end

  assign sync_mode = (sync_cnt == SYNC_HOLD_TRANSMIT_CLOCK);

  // Input word latch and repeated-pattern watch
  logic [9:0] tx_word; // Latest accepted parallel word
  logic [7:0] rmt_cnt; // Repeats of a word with a low-high pair
  logic rmt_word;

  // Pairs end at bit 8; bit 9 sits next to the low stop bit
  assign rmt_word = |(~din_s[8:0] & din_s[9:1]);

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      tx_word <= 10'h000;
      rmt_cnt <= 8'h00;
    end else if (transmit_clock_pick && !sync_mode) begin
      tx_word <= din_s;
      if (rmt_word && din_s == tx_word) begin
        if (rmt_cnt != 8'(RMT_FRAMES)) begin
          rmt_cnt <= rmt_cnt + 8'h01;
        end
      end else begin
        rmt_cnt <= 8'h00;
      end
    end
  end

  // Control register and test state
  logic extest, ext_level, bist_start;
  logic bist_busy, bist_done, bist_pass, have_prev;
  logic [31:0] bist_err, next_err, bist_cnt;
  logic [9:0] prev_rx, bist_tx;
  logic [1:0] bist_warm; // Captures that may still carry pre-test words

  assign bist_start = reg_req_i.wr && reg_req_i.addr == REG_CTRL
                      && reg_req_i.wdata[CTRL_RUNBIST];

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      extest <= CTRL_RESET;
      ext_level <= CTRL_RESET;
    end else if (reg_req_i.wr && reg_req_i.addr == REG_CTRL) begin
      extest <= reg_req_i.wdata[CTRL_EXTEST];
      ext_level <= reg_req_i.wdata[CTRL_EXT_LEVEL];
    end
  end

  // Frame shifter; enable changes leave it running so the state survives
  logic [3:0] tx_idx;
  logic [11:0] tx_shift;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || tx_sleep) begin
      tx_idx <= 4'h0;
      tx_shift <= 12'h000;
    end else if (bit_en) begin
      tx_idx <= (tx_idx == 4'(FRAME_BITS - 1)) ? 4'h0 : tx_idx + 4'h1;
      if (tx_idx == 4'h0) begin
        // Start bit high, data from bit 0, stop bit low
        tx_shift <= sync_mode ? SYNC_FRAME :
                    {1'b1, rev10(bist_busy ? bist_tx : tx_word), 1'b0};
      end else begin
        tx_shift <= {tx_shift[10:0], 1'b0};
      end
    end
  end

  // BIST pattern source, one step per frame
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || bist_start) begin
      bist_tx <= BIST_SEED;
    end else if (bist_busy && bit_en && tx_idx == 4'h0) begin
      bist_tx <= lfsr10(bist_tx);
    end
  end

  // Serial driver; a low enable floats both pins but keeps the shifter
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      serial_p_o <= 1'b0;
      serial_n_o <= 1'b1;
      serial_oe_o <= 1'b0;
      repetitive_multi_transition_o <= 1'b0;
    end else begin
      serial_p_o <= extest ? ext_level : tx_shift[11];
      serial_n_o <= extest ? ~ext_level : ~tx_shift[11];
      serial_oe_o <= !tx_sleep && den_s && (tx_ready || extest);
      repetitive_multi_transition_o <= (rmt_cnt == 8'(RMT_FRAMES));
    end
  end

  // Receiver sampling and clock position search
  rx_state_t rx_state;
  logic rx_sleep, trans, win_end, at_clock, capture, suspect_hit;
  logic [11:0] rx_hist, cand, cand_now;
  logic [3:0] rx_ph, lock_ph, ncand, rel_ph;
  logic [7:0] win_cnt, multi_cnt;
  logic [15:0] slow_cnt;
  logic [9:0] cap_word;

  assign rx_sleep = ~rx_sleep_n_s & ~ren_s;
  // Stop bit low then start bit high marks a candidate clock position
  assign trans = ~rx_hist[0] & sin_s;
  assign cand_now = cand & ~((12'h001 << rx_ph) & {12{~trans}});
  assign ncand = count_ones(cand_now);
  assign win_end = bit_en && rx_ph == 4'(FRAME_BITS - 1)
                   && win_cnt == 8'(WIN_FRAMES - 1);
  assign at_clock = bit_en && rx_ph == lock_ph;
  assign capture = at_clock && trans && rx_state == RX_LOCKED;
  assign cap_word = rev10(rx_hist[10:1]);
  assign suspect_hit = win_end && ncand > 4'h1
                       && multi_cnt == 8'(FALSE_LOCK_WINDOWS - 1);

  // Bit history, phase and candidate mask; sleep stops them like the PLL
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || rx_sleep) begin
      rx_hist <= 12'h000;
      rx_ph <= 4'h0;
      win_cnt <= 8'h00;
      cand <= 12'hfff;
    end else if (bit_en) begin
      rx_hist <= {rx_hist[10:0], sin_s};
      rx_ph <= (rx_ph == 4'(FRAME_BITS - 1)) ? 4'h0 : rx_ph + 4'h1;
      if (rx_ph == 4'(FRAME_BITS - 1)) begin
        win_cnt <= win_end ? 8'h00 : win_cnt + 8'h01;
      end
      cand <= win_end ? 12'hfff : cand_now;
    end
  end

  // Consecutive windows that show more than one clock position
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || rx_sleep) begin
      multi_cnt <= 8'h00;
    end else if (win_end) begin
      if (ncand <= 4'h1) begin
        multi_cnt <= 8'h00;
      end else if (multi_cnt != 8'(FALSE_LOCK_WINDOWS - 1)) begin
        multi_cnt <= multi_cnt + 8'h01;
      end
    end
  end

  // Lock state machine
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || rx_sleep) begin
      rx_state <= RX_SEARCH;
      lock_ph <= 4'h0;
    end else begin
      unique case (rx_state)
        RX_SEARCH: begin
          if (suspect_hit) begin
            rx_state <= RX_SUSPECT;
          end else if (win_end && ncand == 4'h1) begin
            rx_state <= RX_LOCKED;
            lock_ph <= first_one(cand_now);
          end
        end
        RX_LOCKED: begin
          // Suspect first: both drop the lock, but suspect must not be lost
          if (suspect_hit) begin
            rx_state <= RX_SUSPECT;
          end else if (at_clock && !trans) begin
            rx_state <= RX_SEARCH;
          end
        end
        RX_SUSPECT: begin
          // Held off until the pattern stops looking like several clocks
          if (win_end && ncand <= 4'h1) begin
            rx_state <= RX_SEARCH;
          end
        end
        default: begin
          rx_state <= RX_SEARCH;
        end
      endcase
    end
  end

  // Time spent searching; a level once the lock deadline passes
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || rx_sleep || rx_state == RX_LOCKED) begin
      slow_cnt <= 16'h0000;
    end else if (slow_cnt != 16'(LOCK_MAX)) begin
      slow_cnt <= slow_cnt + 16'h0001;
    end
  end

  // Position inside the frame, counted from the start bit
  assign rel_ph = (rx_ph >= lock_ph) ? rx_ph - lock_ph
                                     : rx_ph + 4'(FRAME_BITS) - lock_ph;

  // Receiver outputs; the lock indicator follows the PLL even with data off
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      parallel_data_out_o <= 10'h000;
      recovered_clock_o <= 1'b0;
      rx_out_oe_o <= 1'b0;
      lock_n_o <= 1'b1;
      lock_n_oe_o <= 1'b0;
    end else begin
      if (capture) begin
        parallel_data_out_o <= cap_word;
      end
      recovered_clock_o <= (rx_state == RX_LOCKED) && rel_ph < 4'h6;
      rx_out_oe_o <= !rx_sleep && ren_s && rx_state == RX_LOCKED;
      lock_n_o <= (rx_state != RX_LOCKED);
      lock_n_oe_o <= !rx_sleep;
    end
  end

  // BIST checker: each word must follow the last one through the generator
  assign next_err = (have_prev && cap_word != lfsr10(prev_rx)) ? bist_err + 32'h1 : bist_err;

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      bist_busy <= 1'b0;
      bist_done <= 1'b0;
      bist_pass <= 1'b0;
      have_prev <= 1'b0;
      bist_err <= 32'h0;
      bist_cnt <= 32'h0;
      prev_rx <= 10'h000;
      bist_warm <= 2'h0;
    end else if (bist_start) begin
      bist_busy <= 1'b1;
      bist_done <= 1'b0;
      bist_pass <= 1'b0;
      have_prev <= 1'b0;
      bist_warm <= 2'h3;
      bist_err <= 32'h0;
      bist_cnt <= 32'h0;
    end else if (bist_busy && capture) begin
      // Up to two frames in flight at the start hold data, not test words
      if (bist_warm != 2'h0) begin
        bist_warm <= bist_warm - 2'h1;
      end
      have_prev <= have_prev || bist_warm == 2'h1;
      prev_rx <= cap_word;
      bist_err <= next_err;
      bist_cnt <= bist_cnt + 32'h1;
      if (bist_cnt == 32'(BIST_LEN - 1)) begin
        bist_busy <= 1'b0;
        bist_done <= 1'b1;
        // Errors over bits sent must stay under one in ten million
        bist_pass <= 64'(next_err) * BER_DENOM
                     < 64'(BIST_LEN) * 64'(DATA_BITS);
      end
    end
  end

  // Register read, data valid in the cycle after the strobe only
  status_t status_now;

  assign status_now = '{lock_slow: slow_cnt == 16'(LOCK_MAX), extest_sense: sin_s,
                        repetitive_multi_transition: repetitive_multi_transition_o,
                        suspect: rx_state == RX_SUSPECT,
                        locked: rx_state == RX_LOCKED, bist_busy: bist_busy,
                        bist_complete: bist_done, bist_pass: bist_pass};

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i || !reg_req_i.rd) begin
      reg_rdata_o <= 32'h0;
    end else begin
      unique case (reg_req_i.addr)
        REG_CTRL: reg_rdata_o <= {29'h0, ext_level, extest, bist_busy};
        REG_STATUS: reg_rdata_o <= {24'h0, status_now};
        REG_ERRORS: reg_rdata_o <= bist_err;
        default: reg_rdata_o <= 32'h0;
      endcase
    end
  end

  // Checks next to the logic they guard
  AST_TX_SLEEP_HIZ: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    tx_sleep |=> !serial_oe_o) else $error("Serial driver on during sleep");

  AST_DEN_HIZ: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !den_s |=> !serial_oe_o) else $error("Serial driver on with enable low");

  AST_INIT_GATE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!tx_ready && !extest) |=> !serial_oe_o) else $error("Serial driver on before init");

  AST_RX_SLEEP_HIZ: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    rx_sleep |=> (!lock_n_oe_o && !rx_out_oe_o)) else $error("Receiver driving in sleep");

  AST_LOCK_DRIVEN: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (!ren_s && rx_sleep_n_s) |=> (lock_n_oe_o && !rx_out_oe_o))
    else $error("Lock indicator floated or data driven with enable low");

  AST_SLEEP_RESTART: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    rx_sleep |=> (rx_state == RX_SEARCH) ##1 lock_n_o)
    else $error("Receiver not restarting search after sleep");

  AST_SUSPECT_NO_LOCK: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (rx_state == RX_SUSPECT) |=> lock_n_o) else $error("Lock shown while suspect");

  AST_MULTI_TO_SUSPECT: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (suspect_hit && !rx_sleep) |=> (rx_state == RX_SUSPECT) ##1 lock_n_o)
    else $error("False lock threshold not acted on");

  AST_LOSS_HIZ: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (rx_state == RX_LOCKED && at_clock && !trans && !rx_sleep)
    |=> ##1 (lock_n_o && !rx_out_oe_o)) else $error("Lock loss not shown");

  AST_PASS_BER: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    bist_pass |-> (bist_done && 64'(bist_err) * BER_DENOM < 64'(BIST_LEN) * 64'(DATA_BITS)))
    else $error("BIST pass with too many errors");

endmodule : serdes_lock_power_test_ctrl
